// File: hw/nvm_access_defines.svh
// Constants for the data EEPROM access controller.
// Assumes inclusion by bare name from the package and design modules.
`ifndef NVM_ACCESS_DEFINES_SVH
`define NVM_ACCESS_DEFINES_SVH

// Register indices and byte addresses (address = 4 * index).
`define NVM_CONTROL_IDX 8'h1c
`define NVM_DATA_IDX 8'h1d
`define NVM_ADDRESS_IDX 8'h1e
`define NVM_IRQ_STATUS_IDX 8'h20
`define NVM_IRQ_ENABLE_IDX 8'h21
`define NVM_IRQ_CLEAR_IDX 8'h22
`define NVM_CONTROL_ADDR 12'h070
`define NVM_DATA_ADDR 12'h074
`define NVM_ADDRESS_ADDR 12'h078
`define NVM_IRQ_STATUS_ADDR 12'h080
`define NVM_IRQ_ENABLE_ADDR 12'h084
`define NVM_IRQ_CLEAR_ADDR 12'h088

// Control register fields.
`define CTRL_READ_BIT 0
`define CTRL_LOAD_BIT 1
`define CTRL_UNLOCK_BIT 2
`define CTRL_BUSY_BIT 3

// Address register fields.
`define ADDR_ROW_MSB 6
`define ADDR_ROW_LSB 3
`define ADDR_BYTE_MSB 2

// Interrupt status bits.
`define IRQ_READ_DONE 0
`define IRQ_PROG_DONE 1
`define IRQ_DISCARD 2

// Reset values.
`define NVM_REG_RESET 8'h00
`define IRQ_REG_RESET 3'h0

// Timing.
`define CLK_SYS_HZ 25000000
`define PROG_TIME_US 4000
`define PROG_CYCLES ((`PROG_TIME_US * (`CLK_SYS_HZ / 1000000)))
`define BUSY_DELAY_CYCLES 4
`define PAGE_BYTES 8

`endif

// File: hw/nvm_access_pkg.sv
// Types for the data EEPROM access controller.
// Assumes nvm_access_defines.svh is on the include path.
`include "nvm_access_defines.svh"
package nvm_access_pkg;
   typedef enum logic [1:0] {
      PROG_IDLE = 2'b00,
      PROG_START = 2'b01,
      PROG_BUSY = 2'b10
   } prog_state_t;
endpackage : nvm_access_pkg

// File: hw/nvm_array.sv
// Storage array of 128 bytes with a page program port.
// Assumes callers request one operation at a time on clk_sys.
`timescale 1ns/100ps
`include "nvm_access_defines.svh"
module nvm_array (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Read port.
   input wire logic [6:0] readAddr,
   output logic [7:0] readData,
   // Page program port.
   input wire logic progStrobe,
   input wire logic [3:0] progRow,
   input wire logic [7:0] progMask,
   input wire logic [63:0] progBytes
);
   // Each byte slot of a page owns one bank, so no two processes share it.
   logic [7:0] slotData [0:`PAGE_BYTES-1];

   assign readData = slotData[readAddr[2:0]];

   // Array contents survive reset; only loaded bytes are programmed.
   genvar i;
   generate
      for (i = 0; i < `PAGE_BYTES; i++) begin : gProg
         logic [7:0] bank [0:15];
         assign slotData[i] = bank[readAddr[6:3]];
         always_ff @(posedge clk_sys) begin
            if (rstn && progStrobe && progMask[i]) begin
               bank[progRow] <= progBytes[i*8 +: 8];
            end
         end
      end
   endgenerate
endmodule : nvm_array

// File: hw/nvm_page_access.sv
// Data EEPROM access controller: APB registers, page buffer, programming.
// Assumes an APB master on clk_sys (25 MHz) and asynchronous low resetn.
//
// Behaviour
// R1: Software writes zeros to control bits 7:4.
// R2: Busy bit reads zero, high while programming.
// R3: Software unlocks before writing, relocks after.
// R4: Page field frozen while load bit set.
// R5: Data writes during load fill page buffer.
// R6: Eight bytes per page, each loaded once.
// R7: Clearing load starts programming, busy about 4ms.
// R8: Software waits for busy low before next access.
// R9: Unlock stays set through load and its clear.
// R10: Page write follows unlock, address, load, data order.
// R11: Avoid programming while transmitter enabled.
// R12: Read bit fetches byte, then clears itself.
// R13: Data register holds write byte or last read.
// R14: Address splits into row and byte fields.
// R15: Load cleared while locked discards buffer.
// R16: Registers and buffer reset to zero.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "nvm_access_defines.svh"
module nvm_page_access
   import nvm_access_pkg::*;
#(
   parameter int PROG_CYCLES = `PROG_CYCLES
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt.
   output logic irq
);
   // ****************************************
   // Reset synchroniser
   // ****************************************
   logic rstMeta;
   logic rstn;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rstMeta <= 1'b0;
         rstn <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstn <= rstMeta;
      end
   end

   // ****************************************
   // Bus decode
   // ****************************************
   logic setupPhase;
   logic wrEn;
   logic rdEn;
   logic mapped;
   assign setupPhase = psel && !penable;
   assign wrEn = setupPhase && pwrite;
   assign rdEn = setupPhase && !pwrite;
   always_comb begin
      unique case (paddr)
         `NVM_CONTROL_ADDR, `NVM_DATA_ADDR, `NVM_ADDRESS_ADDR,
         `NVM_IRQ_STATUS_ADDR, `NVM_IRQ_ENABLE_ADDR,
         `NVM_IRQ_CLEAR_ADDR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   logic wrCtrl;
   logic wrData;
   logic wrAddr;
   logic wrIrqEn;
   logic wrIrqClr;
   assign wrCtrl = wrEn && paddr == `NVM_CONTROL_ADDR;
   assign wrData = wrEn && paddr == `NVM_DATA_ADDR;
   assign wrAddr = wrEn && paddr == `NVM_ADDRESS_ADDR;
   assign wrIrqEn = wrEn && paddr == `NVM_IRQ_ENABLE_ADDR;
   assign wrIrqClr = wrEn && paddr == `NVM_IRQ_CLEAR_ADDR;

   // ****************************************
   // Registers
   // ****************************************
   logic unlock_reg;
   logic load_reg;
   logic readReq_reg;
   logic [7:0] nvm_data_reg;
   logic [6:0] nvm_address_reg;
   prog_state_t state_reg;
   logic busy;
   logic [7:0] arrayData;
   logic loadFall;
   assign busy = state_reg == PROG_BUSY;
   assign loadFall = wrCtrl && load_reg && !pwdata[`CTRL_LOAD_BIT];

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         unlock_reg <= 1'b0;  // see R16
         load_reg <= 1'b0;
      end else if (wrCtrl) begin
         unlock_reg <= pwdata[`CTRL_UNLOCK_BIT];
         load_reg <= pwdata[`CTRL_LOAD_BIT];
      end
   end

   // A read is served one cycle after the request, then clears itself.
   logic readDone;
   assign readDone = readReq_reg && !wrCtrl;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         readReq_reg <= 1'b0;
      end else if (wrCtrl) begin
         readReq_reg <= pwdata[`CTRL_READ_BIT];
      end else if (readReq_reg) begin
         readReq_reg <= 1'b0;  // see R12
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         nvm_data_reg <= `NVM_REG_RESET;
      end else if (readDone) begin
         nvm_data_reg <= arrayData;  // see R12 see R13
      end else if (wrData) begin
         nvm_data_reg <= pwdata[7:0];  // see R13
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         nvm_address_reg <= 7'h00;
      end else if (wrAddr) begin
         nvm_address_reg[`ADDR_BYTE_MSB:0] <= pwdata[`ADDR_BYTE_MSB:0];
         if (!load_reg) begin  // see R4
            nvm_address_reg[`ADDR_ROW_MSB:`ADDR_ROW_LSB] <=
               pwdata[`ADDR_ROW_MSB:`ADDR_ROW_LSB];  // see R14
         end
      end
   end

   // ****************************************
   // Page buffer
   // ****************************************
   logic [63:0] pageBytes;
   logic [7:0] pageMask;
   logic progStrobe;
   logic discard;
   assign discard = loadFall && !unlock_reg;  // see R15
   genvar i;
   generate
      for (i = 0; i < `PAGE_BYTES; i++) begin : gSlot
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               pageMask[i] <= 1'b0;  // see R16
               pageBytes[i*8 +: 8] <= 8'h00;
            end else if (discard || progStrobe) begin
               pageMask[i] <= 1'b0;
            end else if (wrData && load_reg &&
                         nvm_address_reg[2:0] == 3'(i)) begin
               pageMask[i] <= 1'b1;  // see R5 see R6
               pageBytes[i*8 +: 8] <= pwdata[7:0];
            end
         end
      end
   endgenerate

   // ****************************************
   // Programming sequencer
   // ****************************************
   logic [17:0] count_reg;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_reg <= PROG_IDLE;
         count_reg <= 18'h00000;
      end else begin
         unique case (state_reg)
            PROG_IDLE: begin
               if (loadFall && unlock_reg) begin  // see R7
                  state_reg <= PROG_START;
                  count_reg <= 18'(`BUSY_DELAY_CYCLES - 1);
               end
            end
            PROG_START: begin
               if (count_reg == 18'h00000) begin
                  state_reg <= PROG_BUSY;  // see R2
                  count_reg <= 18'(PROG_CYCLES - 1);
               end else begin
                  count_reg <= count_reg - 18'h00001;
               end
            end
            PROG_BUSY: begin
               if (count_reg == 18'h00000) begin
                  state_reg <= PROG_IDLE;  // see R7
               end else begin
                  count_reg <= count_reg - 18'h00001;
               end
            end
            default: state_reg <= PROG_IDLE;
         endcase
      end
   end
   assign progStrobe = state_reg == PROG_BUSY && count_reg == 18'h00000;

   nvm_array uArray (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .readAddr(nvm_address_reg),
      .readData(arrayData),
      .progStrobe(progStrobe),
      .progRow(nvm_address_reg[`ADDR_ROW_MSB:`ADDR_ROW_LSB]),
      .progMask(pageMask),
      .progBytes(pageBytes)
   );

   // ****************************************
   // Interrupts
   // ****************************************
   logic [2:0] irqStatus_reg;
   logic [2:0] irqEnable_reg;
   logic [2:0] events;
   assign events = {discard, progStrobe, readDone};
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irqStatus_reg <= `IRQ_REG_RESET;
         irqEnable_reg <= `IRQ_REG_RESET;
         irq <= 1'b0;
      end else begin
         // A new event wins over a clear in the same cycle.
         irqStatus_reg <= (irqStatus_reg & ~(wrIrqClr ? pwdata[2:0] : 3'h0))
                          | events;
         if (wrIrqEn) begin
            irqEnable_reg <= pwdata[2:0];
         end
         irq <= |(irqStatus_reg & irqEnable_reg);
      end
   end

   // ****************************************
   // Read data and answer
   // ****************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setupPhase;
         pslverr <= setupPhase && !mapped;
         if (rdEn) begin
            unique case (paddr)
               `NVM_CONTROL_ADDR:
                  prdata <= {28'h0000000, busy, unlock_reg, load_reg,
                             readReq_reg};  // see R2
               `NVM_DATA_ADDR: prdata <= {24'h000000, nvm_data_reg};
               `NVM_ADDRESS_ADDR: prdata <= {25'h0000000, nvm_address_reg};
               `NVM_IRQ_STATUS_ADDR: prdata <= {29'h00000000, irqStatus_reg};
               `NVM_IRQ_ENABLE_ADDR: prdata <= {29'h00000000, irqEnable_reg};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule : nvm_page_access

// File: tb/nvm_page_access_assertions.sv
// Port checker for the EEPROM access controller.
// Assumes it is bound onto nvm_page_access.
`timescale 1ns/100ps
`include "nvm_access_defines.svh"
module nvm_page_access_checker #(
   parameter int PROG_CYCLES = 20
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Interrupt.
   input wire logic irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   logic [1:0] sinceRead;
   logic [2:0] enShadow;
   logic mapped;
   logic rdCtrl;
   logic wrDone;
   assign wrDone = pready && pwrite;
   assign rdCtrl = pready && !pwrite && paddr == `NVM_CONTROL_ADDR;
   assign mapped = paddr inside {`NVM_CONTROL_ADDR, `NVM_DATA_ADDR,
      `NVM_ADDRESS_ADDR, `NVM_IRQ_STATUS_ADDR, `NVM_IRQ_ENABLE_ADDR,
      `NVM_IRQ_CLEAR_ADDR};
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sinceRead <= 2'h3;
      end else if (wrDone && paddr == `NVM_CONTROL_ADDR && pwdata[0]) begin
         sinceRead <= 2'h0;
      end else if (sinceRead != 2'h3) begin
         sinceRead <= sinceRead + 2'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         enShadow <= 3'h0;
      end else if (wrDone && paddr == `NVM_IRQ_ENABLE_ADDR) begin
         enShadow <= pwdata[2:0];
      end
   end
   // ***
   // Properties.
   // ***
   a_setup_gets_ready: assert property (psel && !penable |=> pready)
      else $error("No pready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_slverr_decode: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr wrong for address");
   a_ctrl_upper_zero: assert property (
      rdCtrl |-> prdata[31:4] == 28'h0) else $error("Control top bits set");
   a_addr_upper_zero: assert property (
      pready && !pwrite && paddr == `NVM_ADDRESS_ADDR
      |-> prdata[31:7] == 25'h0)
      else $error("Address top bits set");
   a_read_self_clear: assert property (
      rdCtrl && sinceRead >= 2'h2 |-> !prdata[0])
      else $error("Read request bit stuck");
   a_reset_quiet: assert property (
      $rose(resetn) |-> !pready && !pslverr && !irq)
      else $error("Outputs active at reset release");
   a_irq_needs_enable: assert property (
      irq |-> enShadow != 3'h0 || $past(enShadow) != 3'h0)
      else $error("Interrupt with all sources disabled");
endmodule : nvm_page_access_checker
bind nvm_page_access nvm_page_access_checker #(.PROG_CYCLES(PROG_CYCLES))
   checker_inst (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// File: tb/cpu_bus_model.sv
// Processor model that drives APB cycles into the controller.
// Assumes calls are made just after a rising edge of clk_sys.
`timescale 1ns/100ps
module cpu_bus_model (
   // Clock.
   input wire logic clk_sys,
   // Requests.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   // Answers.
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel <= 1'h0;
      penable <= 1'h0;
      pwrite <= 1'h0;
      paddr <= 12'h0;
      pwdata <= 32'h0;
   end
   // ***
   // Bus cycle.
   // ***
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      do @(posedge clk_sys); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      // Released lines flip so stale values are never mistaken for live.
      psel <= 1'h0;
      penable <= 1'h0;
      pwrite <= ~w;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge clk_sys);
   endtask : xfer
endmodule : cpu_bus_model

// File: tb/nvm_page_access_tb_top.sv
// Self-checking bench for the EEPROM access controller.
// Assumes cpu_bus_model drives the bus and the checker is bound.
`timescale 1ns/100ps
`include "nvm_access_defines.svh"
module nvm_page_access_tb_top;
   localparam int PROG_CYCLES = 20;
   localparam logic [11:0] CTL = `NVM_CONTROL_ADDR;
   localparam logic [11:0] DAT = `NVM_DATA_ADDR;
   localparam logic [11:0] ADR = `NVM_ADDRESS_ADDR;
   localparam logic [11:0] IST = `NVM_IRQ_STATUS_ADDR;
   localparam logic [11:0] IEN = `NVM_IRQ_ENABLE_ADDR;
   localparam logic [11:0] ICL = `NVM_IRQ_CLEAR_ADDR;
   logic clk_sys = 1'h0;
   logic resetn = 1'h0;
   logic psel, penable, pwrite, pready, pslverr, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   int num_errors = 0;
   int check_count = 0;
   int n;
   logic spanOk;
   always #20 clk_sys = ~clk_sys;
   nvm_page_access #(.PROG_CYCLES(PROG_CYCLES)) nvm_page_access_inst (
      .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq));
   cpu_bus_model cpu_bus_model_inst (.clk_sys(clk_sys), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task automatic check(input string what, input logic [31:0] seen, x);
      check_count++;
      if (seen !== x) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, x, seen);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      cpu_bus_model_inst.xfer(1'h1, a, d, rv, e);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      cpu_bus_model_inst.xfer(1'h0, a, 32'h0, rv, e);
      check($sformatf("reg %h", a), rv, x);
   endtask : rd
   task automatic busy(input logic lvl);
      n = 0;
      do begin
         cpu_bus_model_inst.xfer(1'h0, CTL, 32'h0, rv, e);
         n++;
      end while (rv[`CTRL_BUSY_BIT] !== lvl && n < 100);
      check("busy", {31'h0, rv[`CTRL_BUSY_BIT]}, {31'h0, lvl});
   endtask : busy
   task automatic results;
      $display("Checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   // ***
   // Tests.
   // ***
   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'h1;
      repeat (3) @(posedge clk_sys);
      rd(CTL, 32'h0);
      rd(DAT, 32'h0);
      rd(ADR, 32'h0);
      rd(IST, 32'h0);
      rd(12'h0fc, 32'h0);
      check("slverr", {31'h0, e}, 32'h1);
      wr(IEN, 32'h7);
      wr(ADR, 32'hff);
      rd(ADR, 32'h7f);
      // No transmitter exists here, so programming never overlaps it.
      wr(CTL, 32'h4);
      wr(ADR, 32'h28);
      wr(CTL, 32'h6);
      for (int b = 0; b < 8; b++) begin
         wr(ADR, 32'h10 | b);
         rd(ADR, 32'h28 | b);
         wr(DAT, 32'h30 + b);
      end
      wr(CTL, 32'h4);
      busy(1'h1);
      busy(1'h0);
      spanOk = n * 3 >= PROG_CYCLES - 6 && n * 3 <= PROG_CYCLES + 6;
      check("span", {31'h0, spanOk}, 32'h1);
      rd(IST, 32'h2);
      check("irq", {31'h0, irq}, 32'h1);
      wr(CTL, 32'h0);
      for (int b = 0; b < 8; b++) begin
         wr(ADR, 32'h28 | b);
         wr(CTL, 32'h1);
         rd(CTL, 32'h0);
         rd(DAT, 32'h30 + b);
      end
      wr(IEN, 32'h0);
      check("masked", {31'h0, irq}, 32'h0);
      wr(IEN, 32'h7);
      check("unmasked", {31'h0, irq}, 32'h1);
      wr(ICL, 32'h7);
      check("cleared", {31'h0, irq}, 32'h0);
      wr(ADR, 32'h28);
      wr(CTL, 32'h2);
      wr(DAT, 32'hee);
      rd(DAT, 32'hee);
      wr(CTL, 32'h0);
      repeat (`BUSY_DELAY_CYCLES + 2) @(posedge clk_sys);
      rd(CTL, 32'h0);
      rd(IST, 32'h4);
      wr(CTL, 32'h1);
      rd(DAT, 32'h30);
      // A reset in mid-run must clear the registers and the loaded page.
      wr(ADR, 32'h28);
      wr(CTL, 32'h6);
      wr(DAT, 32'h5a);
      resetn <= 1'h0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'h1;
      repeat (3) @(posedge clk_sys);
      rd(CTL, 32'h0);
      rd(IEN, 32'h0);
      rd(ADR, 32'h0);
      check("reset irq", {31'h0, irq}, 32'h0);
      wr(CTL, 32'h4);
      wr(ADR, 32'h28);
      wr(CTL, 32'h6);
      wr(CTL, 32'h4);
      busy(1'h1);
      busy(1'h0);
      wr(CTL, 32'h0);
      wr(CTL, 32'h1);
      rd(DAT, 32'h30);
      results();
   end
   initial begin
      #200000;
      num_errors++;
      results();
   end
endmodule : nvm_page_access_tb_top
